// ### core/gss_pkg.sv
// Purpose: constants and types of the gain strap and switching clock sync
// Assumes: 25 MHz reference clock; strap code comes from the internal converter
// Notes:   one switching period is split into twelve phase slots
// Behaviour
// - The strap voltage is converted and resolved into one of eight states.
// - The lower four states select primary role with gains 20, 23.5, 32, 36 dB.
// - The upper four states select peripheral role with gains 20, 23.5, 32, 36 dB.
// - Gain and role are caught on the rising edge of reset and then held.
// - A peripheral takes its switching timing from the primary's clock.
// - A peripheral seeing the clock with matched polarity becomes secondary.
// - A peripheral seeing the clock with swapped polarity becomes tertiary.
// - Primary, secondary and tertiary switching sit 30 degrees apart.
// - A primary drives the differential switching clock on its clock pins.
// - An internal power-on reset holds off start-up; a reset rise during the hold is lost.
// - A peripheral keeps its period counter running, reloads it on each link edge and uses the clock pins as inputs.
package gss_pkg;

    localparam int STRAP_W        = 3;
    localparam int STRAP_ROLE_BIT = 2;
    localparam int GAIN_W         = 2;

    // twelve slots of 30 degrees per period
    localparam int PWM_SLOTS      = 12;
    localparam int SLOT_DEG       = 30;
    localparam int FULL_DEG       = 360;
    localparam int PHASE_STEP     = SLOT_DEG * PWM_SLOTS / FULL_DEG;
    localparam int LINK_HI_SLOTS  = 4;
    localparam int SLOT_CYC_DEF   = 4;

    // crossing delay from link edge to the counter reload
    localparam int SYNC_LAT       = 4;

    localparam int REF_CLK_MHZ    = 25;
    localparam int POR_TIME_NS    = 1000;
    localparam int POR_CYC_RAW    = (POR_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int POR_CYC        = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
    localparam int POR_W          = 8;
    localparam int MEAS_W         = 12;

    typedef enum logic [1:0] {
        GSS_GAIN_20DB   = 2'h0,
        GSS_GAIN_23P5DB = 2'h1,
        GSS_GAIN_32DB   = 2'h2,
        GSS_GAIN_36DB   = 2'h3
    } gss_gain_e;

    typedef enum logic [1:0] {
        GSS_PH_PRIMARY   = 2'h0,
        GSS_PH_SECONDARY = 2'h1,
        GSS_PH_TERTIARY  = 2'h2,
        GSS_PH_NONE      = 2'h3
    } gss_phase_e;

    // gray order along idle, wait, measure, run
    typedef enum logic [1:0] {
        GSS_ST_IDLE    = 2'h0,
        GSS_ST_WAIT    = 2'h1,
        GSS_ST_MEASURE = 2'h3,
        GSS_ST_RUN     = 2'h2
    } gss_state_e;

    typedef struct packed {
        logic       primary;
        gss_gain_e  gain;
        gss_phase_e phase;
    } gss_cfg_s;

    typedef struct packed {
        logic plus;
        logic plus_oe_n;
        logic minus;
        logic minus_oe_n;
    } gss_osc_drv_s;

    localparam gss_cfg_s     CFG_RST = '{1'b0, GSS_GAIN_20DB, GSS_PH_NONE};
    localparam gss_osc_drv_s DRV_OFF = '{1'b0, 1'b1, 1'b0, 1'b1};

endpackage

// ### core/gss_top.sv
// Purpose: strap latch, role and phase selection, switching clock sync
// Assumes: link_clk_i is the differential receiver output of the clock pins
// Notes:   clock pin enables are low while this device drives them
`timescale 1ns/1ps
module gss_top #(
    parameter int SLOT_CYC = gss_pkg::SLOT_CYC_DEF
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       link_clk_i,
    input  wire logic                       amp_reset_n_i,
    input  wire logic [gss_pkg::STRAP_W-1:0] strap_code_i,
    input  wire logic                       osc_clock_plus_i,
    input  wire logic                       osc_clock_minus_i,
    output logic                            cfg_valid_o,
    output gss_pkg::gss_cfg_s               cfg_o,
    output logic                            switch_run_o,
    output logic                            switch_clk_o,
    output gss_pkg::gss_osc_drv_s           osc_drv_o
);
    import gss_pkg::*;

    localparam int PERIOD_CYC = PWM_SLOTS * SLOT_CYC;
    localparam int HALF_CYC   = PERIOD_CYC / 2;
    localparam int LINK_HI    = LINK_HI_SLOTS * SLOT_CYC;
    localparam int STEP_CYC   = PHASE_STEP * SLOT_CYC;
    localparam int CNT_W      = $clog2(2 * PERIOD_CYC);

    // elaboration check: period must hold the link high time and both offsets
    if (SLOT_CYC < 2 || PERIOD_CYC <= SYNC_LAT + LINK_HI + 2 * STEP_CYC) begin : g_bad_slot
        $error("gss_top: SLOT_CYC too small");
    end

    typedef struct packed {
        gss_state_e          st;
        logic [STRAP_W-1:0]  strap_m;
        logic [STRAP_W-1:0]  strap_s;
        logic                rstn_m;
        logic                rstn_s;
        logic                rstn_d;
        logic                plus_m;
        logic                plus_s;
        logic                minus_m;
        logic                minus_s;
        logic                tog_m;
        logic                tog_s;
        logic                tog_d;
        logic [POR_W-1:0]    por_cnt;
        logic [CNT_W-1:0]    cnt;
        logic [CNT_W-1:0]    reload;
        logic [MEAS_W-1:0]   hi_cnt;
        logic [MEAS_W-1:0]   per_cnt;
        logic                valid;
        gss_cfg_s            cfg;
        logic                run;
        logic                sw_clk;
        gss_osc_drv_s        drv;
    } gss_state_s;

    gss_state_s state_reg;
    gss_state_s state_next;

    // link domain: reset sync and edge toggle
    logic lrst_m_reg;
    logic lrst_s_reg;
    logic ltog_reg;

    logic             por_done;
    logic             rst_rise;
    logic             link_edge;
    logic             diff_hi;
    logic [CNT_W-1:0] off;
    logic [CNT_W-1:0] shifted;

    // link side: one toggle per received clock rising edge
    always_ff @(posedge link_clk_i) begin
        lrst_m_reg <= reset_i;
        lrst_s_reg <= lrst_m_reg;
        if (lrst_s_reg) begin
            ltog_reg <= 1'b0;
        end else begin
            ltog_reg <= ~ltog_reg;
        end
    end

    // decoded events from the power-on count and synchronised levels
    assign por_done  = (state_reg.por_cnt == POR_W'(POR_CYC));
    assign rst_rise  = state_reg.rstn_s & ~state_reg.rstn_d;
    assign link_edge = state_reg.tog_s ^ state_reg.tog_d;
    assign diff_hi   = state_reg.plus_s & ~state_reg.minus_s;

    // phase offset of this device, one step per role
    always_comb begin
        off = CNT_W'(STEP_CYC) * CNT_W'(state_reg.cfg.phase);
        if (state_reg.cfg.phase == GSS_PH_NONE) begin
            off = '0;
        end
        if (state_reg.cnt >= off) begin
            shifted = state_reg.cnt - off;
        end else begin
            shifted = state_reg.cnt + CNT_W'(PERIOD_CYC) - off;
        end
    end

    // next state
    always_comb begin
        state_next         = state_reg;
        state_next.strap_m = strap_code_i;
        state_next.strap_s = state_reg.strap_m;
        state_next.rstn_m  = amp_reset_n_i;
        state_next.rstn_s  = state_reg.rstn_m;
        state_next.rstn_d  = state_reg.rstn_s;
        state_next.plus_m  = osc_clock_plus_i;
        state_next.plus_s  = state_reg.plus_m;
        state_next.minus_m = osc_clock_minus_i;
        state_next.minus_s = state_reg.minus_m;
        state_next.tog_m   = ltog_reg;
        state_next.tog_s   = state_reg.tog_m;
        state_next.tog_d   = state_reg.tog_s;

        // power-on hold before any start
        if (!por_done) begin
            state_next.por_cnt = state_reg.por_cnt + POR_W'(1);
        end

        // free period counter
        if (state_reg.cnt >= CNT_W'(PERIOD_CYC - 1)) begin
            state_next.cnt = '0;
        end else begin
            state_next.cnt = state_reg.cnt + CNT_W'(1);
        end

        case (state_reg.st)
            GSS_ST_IDLE: begin
                state_next.run = 1'b0;
                if (por_done && rst_rise) begin
                    state_next.valid       = 1'b1;
                    state_next.cfg.gain    = gss_gain_e'(state_reg.strap_s[GAIN_W-1:0]);
                    state_next.cfg.primary = ~state_reg.strap_s[STRAP_ROLE_BIT];
                    state_next.cnt         = '0;
                    if (!state_reg.strap_s[STRAP_ROLE_BIT]) begin
                        state_next.cfg.phase = GSS_PH_PRIMARY;
                        state_next.run       = 1'b1;
                        state_next.st        = GSS_ST_RUN;
                    end else begin
                        state_next.cfg.phase = GSS_PH_NONE;
                        state_next.st        = GSS_ST_WAIT;
                    end
                end
            end
            GSS_ST_WAIT: begin
                if (link_edge) begin
                    state_next.hi_cnt  = '0;
                    state_next.per_cnt = '0;
                    state_next.st      = GSS_ST_MEASURE;
                end
            end
            GSS_ST_MEASURE: begin
                // high time versus period tells the wiring polarity
                if (state_reg.per_cnt != '1) begin
                    state_next.per_cnt = state_reg.per_cnt + MEAS_W'(1);
                    state_next.hi_cnt  = state_reg.hi_cnt + MEAS_W'(diff_hi);
                end
                if (link_edge) begin
                    state_next.run = 1'b1;
                    state_next.st  = GSS_ST_RUN;
                    if ({state_reg.hi_cnt, 1'b0} < {1'b0, state_reg.per_cnt}) begin
                        state_next.cfg.phase = GSS_PH_SECONDARY;
                        state_next.reload    = CNT_W'(SYNC_LAT);
                    end else begin
                        state_next.cfg.phase = GSS_PH_TERTIARY;
                        state_next.reload    = CNT_W'(SYNC_LAT + LINK_HI);
                    end
                    state_next.cnt = state_next.reload;
                end
            end
            GSS_ST_RUN: begin
                // peripheral keeps tracking every primary edge
                if (!state_reg.cfg.primary && link_edge) begin
                    state_next.cnt = state_reg.reload;
                end
            end
            default: begin
                state_next.st = GSS_ST_IDLE;
            end
        endcase

        // held reset stops switching and returns to idle; strap is not looked at
        if (!state_reg.rstn_s) begin
            state_next.st  = GSS_ST_IDLE;
            state_next.run = 1'b0;
        end

        // switching reference with this device's offset
        state_next.sw_clk = state_reg.run && (shifted < CNT_W'(HALF_CYC));

        // primary drives the pins, peripheral leaves them as inputs
        state_next.drv = DRV_OFF;
        if (state_reg.run && state_reg.cfg.primary) begin
            state_next.drv.plus       = (state_reg.cnt < CNT_W'(LINK_HI));
            state_next.drv.minus      = ~(state_reg.cnt < CNT_W'(LINK_HI));
            state_next.drv.plus_oe_n  = 1'b0;
            state_next.drv.minus_oe_n = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg         <= '0;
            state_reg.st      <= GSS_ST_IDLE;
            state_reg.rstn_d  <= 1'b1;
            state_reg.cfg     <= CFG_RST;
            state_reg.drv     <= DRV_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign cfg_valid_o  = state_reg.valid;
    assign cfg_o        = state_reg.cfg;
    assign switch_run_o = state_reg.run;
    assign switch_clk_o = state_reg.sw_clk;
    assign osc_drv_o    = state_reg.drv;

    // checks on the reference domain
    localparam int PERIOD_A = PERIOD_CYC;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence seq_release;
        state_reg.st == GSS_ST_IDLE && por_done && rst_rise && state_reg.rstn_s;
    endsequence

    sequence seq_pol_done;
        state_reg.st == GSS_ST_MEASURE && link_edge && state_reg.rstn_s;
    endsequence

    // latch with the role bit set: peripheral waits for the primary clock
    sequence seq_per_latch;
        state_reg.st == GSS_ST_IDLE && por_done && rst_rise && state_reg.rstn_s
            && state_reg.strap_s[STRAP_ROLE_BIT];
    endsequence

    AST_DECODE: assert property (seq_release |=>
        cfg_o.gain == gss_gain_e'($past(state_reg.strap_s[GAIN_W-1:0])) && cfg_valid_o)
        else $error("gain not decoded from strap");

    AST_ROLE: assert property (seq_release |=>
        cfg_o.primary == !$past(state_reg.strap_s[STRAP_ROLE_BIT]))
        else $error("role not decoded from strap");

    AST_HOLD: assert property (state_reg.st != GSS_ST_IDLE && state_reg.rstn_s
        |=> $stable(cfg_o.gain) && $stable(cfg_o.primary))
        else $error("strap setting changed while reset high");

    AST_SECONDARY: assert property ((seq_pol_done
        and ({state_reg.hi_cnt, 1'b0} < {1'b0, state_reg.per_cnt}))
        |=> cfg_o.phase == GSS_PH_SECONDARY && switch_run_o)
        else $error("matched polarity not secondary");

    AST_TERTIARY: assert property ((seq_pol_done
        and !({state_reg.hi_cnt, 1'b0} < {1'b0, state_reg.per_cnt}))
        |=> cfg_o.phase == GSS_PH_TERTIARY && switch_run_o)
        else $error("swapped polarity not tertiary");

    AST_PER_WAIT: assert property (seq_per_latch |=>
        !switch_run_o && cfg_o.phase == GSS_PH_NONE && cfg_valid_o)
        else $error("peripheral started before clock seen");

    AST_PRI_DRIVE: assert property (switch_run_o && cfg_o.primary |=>
        !osc_drv_o.plus_oe_n && !osc_drv_o.minus_oe_n
        && osc_drv_o.minus == !osc_drv_o.plus)
        else $error("primary clock pins not driven");

    AST_PHASE_ON: assert property (switch_run_o && state_reg.cnt == off
        |=> switch_clk_o)
        else $error("switching edge not at phase offset");

    AST_PHASE_OFF: assert property (switch_run_o
        && state_reg.cnt == off + CNT_W'(HALF_CYC)
        |=> !switch_clk_o)
        else $error("switching half period wrong");

    AST_PRI_CLK: assert property (switch_run_o && cfg_o.primary
        && $rose(osc_drv_o.plus) ##1 switch_run_o [*1] |-> ##(PERIOD_A - 1)
        (!switch_run_o || $rose(osc_drv_o.plus)))
        else $error("primary clock period wrong");

    AST_PERIPH_IN: assert property (!cfg_o.primary |->
        osc_drv_o.plus_oe_n && osc_drv_o.minus_oe_n)
        else $error("peripheral drives clock pins");

    AST_PRI_ALIGN: assert property (switch_run_o && cfg_o.primary
        && state_reg.cnt == '0 && state_reg.rstn_s |=> $rose(switch_clk_o))
        else $error("primary switching not at phase zero");

    AST_STOP: assert property (!state_reg.rstn_s |=> !switch_run_o ##1 !switch_clk_o)
        else $error("switching while reset held");

    AST_START: assert property ($rose(switch_run_o) |-> cfg_valid_o && por_done)
        else $error("switching before latch");

endmodule

// ### tb/gss_prim_model.sv
// Purpose: behavioural primary device driving the differential switching clock
// Assumes: pins fall back to the board pull levels, plus low and minus high, when off
// Notes:   ticks on its own 12 ns clock, period of 160 ticks, plus high for 53
`timescale 1ns/1ps
module gss_prim_model #(
    parameter int DIV = 160,
    parameter int HI  = 53
) (
    input  wire logic en_i,
    output logic      plus_o,
    output logic      minus_o
);
    logic tick_clk;
    int   cnt;

    // free link time base, unrelated in phase to the reference clock
    initial tick_clk = 1'b0;
    always #6 tick_clk = ~tick_clk;

    // period counter, held at zero while the primary is off
    always_ff @(posedge tick_clk) begin
        cnt <= (!en_i || cnt == DIV - 1) ? 0 : cnt + 1;
    end

    // differential clock out, minus inverse of plus, pull levels when off
    assign plus_o  = en_i && (cnt < HI);
    assign minus_o = !en_i || (cnt >= HI);
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench of strap latch, primary clock out and peripheral sync
// Assumes: bench drives on the falling edge of the reference clock
// Notes:   link clock is the received difference of the two clock pins
`timescale 1ns/1ps
module testbench;
    import gss_pkg::*;
    localparam int SC  = 4;
    localparam int PER = 12 * SC;

    logic               ref_clk;
    logic               reset;
    logic               amp_rst_n;
    logic               swap;
    logic               m_en;
    logic [STRAP_W-1:0] strap;
    logic               m_plus;
    logic               m_minus;
    logic               pin_plus;
    logic               pin_minus;
    logic               link_clk;
    logic               cfg_valid;
    logic               switch_run;
    logic               switch_clk;
    gss_cfg_s           cfg;
    gss_osc_drv_s       drv;
    int                 fail_count = 0;
    int                 samples_checked = 0;

    // reference clock, 40 ns period
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // pin levels from whoever drives them, peripheral wiring may be swapped
    assign pin_plus  = !drv.plus_oe_n ? drv.plus : (swap ? m_minus : m_plus);
    assign pin_minus = !drv.minus_oe_n ? drv.minus : (swap ? m_plus : m_minus);
    assign link_clk  = pin_plus & ~pin_minus;

    gss_prim_model i_prim (.en_i(m_en), .plus_o(m_plus), .minus_o(m_minus));

    gss_top #(.SLOT_CYC(SC)) i_dut (
        .ref_clk_i        (ref_clk),
        .reset_i          (reset),
        .link_clk_i       (link_clk),
        .amp_reset_n_i    (amp_rst_n),
        .strap_code_i     (strap),
        .osc_clock_plus_i (pin_plus),
        .osc_clock_minus_i(pin_minus),
        .cfg_valid_o      (cfg_valid),
        .cfg_o            (cfg),
        .switch_run_o     (switch_run),
        .switch_clk_o     (switch_clk),
        .osc_drv_o        (drv)
    );

    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // final report and verdict
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // bounded wait on cfg_valid (sel 0) or switch_run (sel 1)
    task automatic wait_hi(input int sel, input int bound);
        int n;
        n = 0;
        while (((sel == 0) ? cfg_valid : switch_run) !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > bound) begin
                check("timeout", 8'h0, 8'h1);
                end_sim();
            end
        end
    endtask

    // logic reset with device pin low, then past the power-on hold
    task automatic do_reset(input int hold);
        @(negedge ref_clk);
        reset     = 1'b1;
        amp_rst_n = 1'b0;
        repeat (hold) @(negedge ref_clk);
        reset = 1'b0;
        repeat (30) @(negedge ref_clk);
    endtask

    // pin rise inside the power-on hold is lost, a later rise latches
    task automatic t_por();
        m_en  = 1'b0;
        strap = 3'h1;
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        repeat (5) @(negedge ref_clk);
        amp_rst_n = 1'b1;
        repeat (40) @(negedge ref_clk);
        check("early_rise_lost", cfg_valid, 8'h0);
        amp_rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        amp_rst_n = 1'b1;
        wait_hi(0, 20);
        check("late_rise_gain", cfg.gain, GSS_GAIN_23P5DB);
    endtask

    // primary: latch, clock out with 1/3 duty, strap ignored, stop on reset pin
    task automatic t_primary(input logic [1:0] g);
        int hi;
        int inv;
        hi  = 0;
        inv = 0;
        m_en  = 1'b0;
        swap  = 1'b0;
        strap = {1'b0, g};
        do_reset(12);
        check("run_before_latch", switch_run, 8'h0);
        amp_rst_n = 1'b1;
        wait_hi(0, 20);
        check("cfg_primary", cfg, {1'b1, g, GSS_PH_PRIMARY});
        strap = 3'h7;
        wait_hi(1, 20);
        repeat (PER) begin
            @(negedge ref_clk);
            hi += pin_plus;
            inv += (pin_minus !== ~pin_plus);
        end
        check("plus_high_cycles", 8'(hi), 8'(4 * SC));
        check("minus_inverse", 8'(inv), 8'h0);
        check("pins_driven", {drv.plus_oe_n, drv.minus_oe_n}, 8'h0);
        check("cfg_held", cfg, {1'b1, g, GSS_PH_PRIMARY});
        amp_rst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("run_stopped", switch_run, 8'h0);
    endtask

    // peripheral: role from strap, phase from pin polarity, switching at link rate
    task automatic t_periph(input logic [1:0] g, input logic sw);
        int hi;
        hi    = 0;
        m_en  = 1'b1;
        swap  = sw;
        strap = {1'b1, g};
        do_reset(160);
        amp_rst_n = 1'b1;
        wait_hi(0, 20);
        check("cfg_periph", {cfg.primary, cfg.gain}, {1'b0, g});
        wait_hi(1, 400);
        check("phase", cfg.phase, sw ? GSS_PH_TERTIARY : GSS_PH_SECONDARY);
        check("pins_released", {drv.plus_oe_n, drv.minus_oe_n}, 8'h3);
        repeat (PER) begin
            @(negedge ref_clk);
            hi += switch_clk;
        end
        check("switch_half_period", 8'(hi), 8'(PER / 2));
    endtask

    // main sequence
    initial begin
        reset     = 1'b1;
        amp_rst_n = 1'b0;
        swap      = 1'b0;
        m_en      = 1'b0;
        strap     = 3'h0;
        t_por();
        for (int g = 0; g < 4; g++) begin
            t_primary(2'(g));
            t_periph(2'(g), g[0]);
        end
        end_sim();
    end
endmodule
